/* File: lpc_pkg.sv */
package lpc_pkg;

    // ==========================================================
    // Register map
    localparam logic [31:0] OFS_PANEL_CONFIG = 32'h1305_0000;
    localparam logic [31:0] OFS_VSYNC_PULSE_POS = 32'h1305_0004;
    localparam logic [31:0] OFS_HSYNC_PULSE_POS = 32'h1305_0008;
    localparam logic [31:0] OFS_VIRTUAL_AREA_SIZE = 32'h1305_000c;
    localparam logic [31:0] OFS_DISPLAY_AREA_HORIZ = 32'h1305_0010;
    localparam logic [31:0] OFS_DISPLAY_AREA_VERT = 32'h1305_0014;
    localparam logic [31:0] OFS_POWER_SIG_TIMING = 32'h1305_0018;
    localparam logic [31:0] OFS_LINE_CLEAR_SIG_TIMING = 32'h1305_001c;
    localparam logic [31:0] OFS_START_PULSE_SIG_TIMING = 32'h1305_0020;
    localparam logic [31:0] OFS_REVERSE_SIG_TIMING = 32'h1305_0024;
    localparam logic [31:0] OFS_CONTROLLER_CONTROL = 32'h1305_0030;
    localparam logic [31:0] OFS_CONTROLLER_STATE = 32'h1305_0034;
    localparam logic [31:0] OFS_INTERRUPT_FRAME_ID = 32'h1305_0038;
    localparam logic [31:0] OFS_DESCRIPTOR_ADDR_A = 32'h1305_0040;
    localparam logic [31:0] OFS_SOURCE_ADDR_A = 32'h1305_0044;
    localparam logic [31:0] OFS_FRAME_ID_A = 32'h1305_0048;
    localparam logic [31:0] OFS_DMA_COMMAND_A = 32'h1305_004c;
    localparam logic [31:0] OFS_DESCRIPTOR_ADDR_B = 32'h1305_0050;
    localparam logic [31:0] OFS_SOURCE_ADDR_B = 32'h1305_0054;
    localparam logic [31:0] OFS_FRAME_ID_B = 32'h1305_0058;
    localparam logic [31:0] OFS_DMA_COMMAND_B = 32'h1305_005c;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [31:0] MASK_CONFIG = 32'h80ff_ffbf;
    localparam logic [31:0] MASK_TWO_FLD = 32'h07ff_07ff;
    localparam logic [31:0] MASK_LO_FLD = 32'h0000_07ff;
    localparam logic [31:0] MASK_HI_FLD = 32'h07ff_0000;
    localparam int unsigned HI_LSB = 16;
    localparam int unsigned CTRL_ENABLE_BIT = 3;

    // ==========================================================
    // Display type codes
    localparam logic [3:0] MODE_TFT_GENERIC = 4'h0;
    localparam logic [3:0] MODE_TFT_SPECIAL1 = 4'h1;
    localparam logic [3:0] MODE_TFT_SPECIAL3 = 4'h3;
    localparam logic [3:0] MODE_CCIR_PROG = 4'h4;
    localparam logic [3:0] MODE_CCIR_INTL = 4'h6;
    localparam logic [3:0] MODE_STN_SGL_CLR = 4'h8;
    localparam logic [3:0] MODE_STN_SGL_MONO = 4'h9;
    localparam logic [3:0] MODE_STN_DUAL_CLR = 4'ha;
    localparam logic [3:0] MODE_STN_DUAL_MONO = 4'hb;
    localparam logic [3:0] MODE_TFT_SERIAL8 = 4'hc;

    // ==========================================================
    // Data pin masks
    localparam logic [17:0] DMASK_18 = 18'h3ffff;
    localparam logic [17:0] DMASK_16 = 18'h0ffff;
    localparam logic [17:0] DMASK_8 = 18'h000ff;
    localparam logic [17:0] DMASK_4 = 18'h0000f;
    localparam logic [17:0] DMASK_2 = 18'h00003;
    localparam logic [17:0] DMASK_1 = 18'h00001;
    localparam logic [17:0] DMASK_DUAL4 = 18'h00f0f;
    localparam logic [17:0] DMASK_NONE = 18'h00000;

    typedef struct packed {
        logic pin_group_select;
        logic [6:0] rsv_hi;
        logic power_sig_disable;
        logic line_clear_sig_disable;
        logic start_pulse_sig_disable;
        logic reverse_sig_disable;
        logic hsync_pol_func_disable;
        logic pixclk_pol_func_disable;
        logic data_invert;
        logic sync_direction;
        logic power_pin_idle_level;
        logic line_clear_pin_idle_level;
        logic start_pulse_pin_idle_level;
        logic reverse_pin_idle_level;
        logic hsync_polarity;
        logic pixclk_polarity;
        logic data_enable_polarity;
        logic vsync_polarity;
        logic tft_18bit;
        logic rsv_6;
        logic [1:0] passive_data_width;
        logic [3:0] mode;
    } lpc_cfg_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic sync_oe;
        logic panel_data_enable;
        logic panel_power_signal;
        logic line_clear;
        logic start_pulse;
        logic reverse;
    } lpc_pins_t;

endpackage : lpc_pkg

/* File: lpc_panel_out.sv */
// Overview of operation
// - Config bit 31 picks parallel pins at 0, smart panel interface at 1.
// - Bits 23..20 enable power, line-clear, start-pulse, reverse pins when 0.
// - Bit 19 at 1 ignores the hsync polarity choice.
// - Bit 18 at 1 ignores the pixel clock polarity choice.
// - Bit 17 at 1 inverts pixel data on the data lines the type enables.
// - Bit 16 at 0 drives both sync pins; at 1 they are inputs.
// - Bit 11 makes hsync active low when set.
// - Bit 10 moves data changes from rising to falling pixel clock edge.
// - Bit 9 makes data enable active low when set.
// - Bit 8 makes the vsync leading edge falling when set.
// - Bit 7 picks 18-bit over 16-bit TFT bus only in types 00xx.
// - Passive width field sets STN data lines, single or dual mono.
// - Type 0000 generic TFT, 0100 progressive, 0110 interlaced CCIR656.
// - Types 0001-0011 special TFT, 1100 serial TFT, 1000-1011 STN; others reserved.
// - Special signal timing registers act only in special TFT modes.
// - Second descriptor set used only for dual STN panels.
// - Config bits 30:24 and 6 read zero, writes ignored.
// - Horizontal positions count pixel clocks, vertical positions count lines.
// - Vsync pulse always starts at position zero.
`timescale 1ns/1ps
`default_nettype none

module lpc_panel_out (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_pclk_pin,
    input wire logic [17:0] i_pix_data,
    output logic o_pix_take,
    output logic [17:0] o_data,
    output lpc_pkg::lpc_pins_t o_pins,
    output logic o_smart_panel_interface,
    output logic o_dual_desc_en,
    output logic o_mode_reserved
);
    import lpc_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [10:0] fld_lo(input logic [31:0] r);
        fld_lo = r[10:0];
    endfunction : fld_lo

    function automatic logic [10:0] fld_hi(input logic [31:0] r);
        fld_hi = r[HI_LSB+10:HI_LSB];
    endfunction : fld_hi

    // Start inclusive, end exclusive
    function automatic logic in_win(input logic [10:0] p, input logic [10:0] s,
                                    input logic [10:0] e);
        in_win = (p >= s) && (p < e);
    endfunction : in_win

    function automatic logic [17:0] data_mask(input lpc_cfg_t c);
        logic [17:0] m;
        m = DMASK_NONE;
        if (c.mode[3:2] == 2'b00)
        begin
            m = c.tft_18bit ? DMASK_18 : DMASK_16;
        end
        if ((c.mode == MODE_CCIR_PROG) || (c.mode == MODE_CCIR_INTL))
        begin
            m = DMASK_8;
        end
        if (c.mode == MODE_TFT_SERIAL8)
        begin
            m = DMASK_8;
        end
        if (c.mode[3:2] == 2'b10)
        begin
            if (c.mode == MODE_STN_DUAL_MONO)
            begin
                case (c.passive_data_width)
                    2'b10: m = DMASK_DUAL4;
                    2'b11: m = DMASK_16;
                    default: m = DMASK_NONE;
                endcase
            end
            else
            begin
                case (c.passive_data_width)
                    2'b00: m = DMASK_1;
                    2'b01: m = DMASK_2;
                    2'b10: m = DMASK_4;
                    default: m = DMASK_8;
                endcase
            end
        end
        data_mask = m;
    endfunction : data_mask

    // ==========================================================
    // Registers
    lpc_cfg_t cfg_q, cfg_d;
    logic [31:0] vsync_q, vsync_d, hsync_q, hsync_d, vat_q, vat_d;
    logic [31:0] dah_q, dah_d, dav_q, dav_d, ps_q, ps_d, cls_q, cls_d;
    logic [31:0] spl_q, spl_d, rev_q, rev_d, ctrl_q, ctrl_d, state_q, state_d;
    logic [31:0] da0_q, da0_d, da1_q, da1_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [10:0] h_q, v_q;
    logic acc, wr_go, hit;
    logic [31:0] rd_val;

    // ==========================================================
    // APB slave: one wait state, write commits with pready
    always_comb
    begin
        acc = i_psel && i_penable && !pready_q;
        wr_go = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
        hit = 1'b1;
        rd_val = RST_REG;
        if (i_paddr == OFS_PANEL_CONFIG)
            rd_val = cfg_q & MASK_CONFIG;
        else if (i_paddr == OFS_VSYNC_PULSE_POS)
            rd_val = vsync_q;
        else if (i_paddr == OFS_HSYNC_PULSE_POS)
            rd_val = hsync_q;
        else if (i_paddr == OFS_VIRTUAL_AREA_SIZE)
            rd_val = vat_q;
        else if (i_paddr == OFS_DISPLAY_AREA_HORIZ)
            rd_val = dah_q;
        else if (i_paddr == OFS_DISPLAY_AREA_VERT)
            rd_val = dav_q;
        else if (i_paddr == OFS_POWER_SIG_TIMING)
            rd_val = ps_q;
        else if (i_paddr == OFS_LINE_CLEAR_SIG_TIMING)
            rd_val = cls_q;
        else if (i_paddr == OFS_START_PULSE_SIG_TIMING)
            rd_val = spl_q;
        else if (i_paddr == OFS_REVERSE_SIG_TIMING)
            rd_val = rev_q;
        else if (i_paddr == OFS_CONTROLLER_CONTROL)
            rd_val = ctrl_q;
        else if (i_paddr == OFS_CONTROLLER_STATE)
            rd_val = state_q;
        else if (i_paddr == OFS_INTERRUPT_FRAME_ID)
            rd_val = RST_REG;
        else if (i_paddr == OFS_DESCRIPTOR_ADDR_A)
            rd_val = da0_q;
        else if (i_paddr == OFS_SOURCE_ADDR_A)
            // Live scan position, handy for bring-up
            rd_val = {5'h00, h_q, 5'h00, v_q};
        else if (i_paddr == OFS_FRAME_ID_A || i_paddr == OFS_DMA_COMMAND_A)
            rd_val = RST_REG;
        else if (i_paddr == OFS_DESCRIPTOR_ADDR_B)
            rd_val = da1_q;
        else if (i_paddr == OFS_SOURCE_ADDR_B || i_paddr == OFS_FRAME_ID_B)
            rd_val = RST_REG;
        else if (i_paddr == OFS_DMA_COMMAND_B)
            rd_val = RST_REG;
        else
            hit = 1'b0;

        pready_d = acc;
        pslverr_d = acc && !hit;
        prdata_d = (acc && !i_pwrite && hit) ? rd_val : RST_REG;

        cfg_d = cfg_q;
        vsync_d = vsync_q;
        hsync_d = hsync_q;
        vat_d = vat_q;
        dah_d = dah_q;
        dav_d = dav_q;
        ps_d = ps_q;
        cls_d = cls_q;
        spl_d = spl_q;
        rev_d = rev_q;
        ctrl_d = ctrl_q;
        state_d = state_q;
        da0_d = da0_q;
        da1_d = da1_q;
        if (wr_go)
        begin
            if (i_paddr == OFS_PANEL_CONFIG)
                cfg_d = lpc_cfg_t'(i_pwdata & MASK_CONFIG);
            else if (i_paddr == OFS_VSYNC_PULSE_POS)
                vsync_d = i_pwdata & MASK_LO_FLD;
            else if (i_paddr == OFS_HSYNC_PULSE_POS)
                hsync_d = i_pwdata & MASK_TWO_FLD;
            else if (i_paddr == OFS_VIRTUAL_AREA_SIZE)
                vat_d = i_pwdata & MASK_TWO_FLD;
            else if (i_paddr == OFS_DISPLAY_AREA_HORIZ)
                dah_d = i_pwdata & MASK_TWO_FLD;
            else if (i_paddr == OFS_DISPLAY_AREA_VERT)
                dav_d = i_pwdata & MASK_TWO_FLD;
            else if (i_paddr == OFS_POWER_SIG_TIMING)
                ps_d = i_pwdata & MASK_TWO_FLD;
            else if (i_paddr == OFS_LINE_CLEAR_SIG_TIMING)
                cls_d = i_pwdata & MASK_TWO_FLD;
            else if (i_paddr == OFS_START_PULSE_SIG_TIMING)
                spl_d = i_pwdata & MASK_TWO_FLD;
            else if (i_paddr == OFS_REVERSE_SIG_TIMING)
                rev_d = i_pwdata & MASK_HI_FLD;
            else if (i_paddr == OFS_CONTROLLER_CONTROL)
                ctrl_d = i_pwdata;
            else if (i_paddr == OFS_CONTROLLER_STATE)
                state_d = i_pwdata;
            else if (i_paddr == OFS_DESCRIPTOR_ADDR_A)
                da0_d = i_pwdata;
            else if (i_paddr == OFS_DESCRIPTOR_ADDR_B)
                da1_d = i_pwdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cfg_q <= lpc_cfg_t'(RST_REG);
            vsync_q <= RST_REG;
            hsync_q <= RST_REG;
            vat_q <= RST_REG;
            dah_q <= RST_REG;
            dav_q <= RST_REG;
            ps_q <= RST_REG;
            cls_q <= RST_REG;
            spl_q <= RST_REG;
            rev_q <= RST_REG;
            ctrl_q <= RST_REG;
            state_q <= RST_REG;
            da0_q <= RST_REG;
            da1_q <= RST_REG;
            prdata_q <= RST_REG;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            vsync_q <= vsync_d;
            hsync_q <= hsync_d;
            vat_q <= vat_d;
            dah_q <= dah_d;
            dav_q <= dav_d;
            ps_q <= ps_d;
            cls_q <= cls_d;
            spl_q <= spl_d;
            rev_q <= rev_d;
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            da0_q <= da0_d;
            da1_q <= da1_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ==========================================================
    // Scan and pin stage, paced by the sampled pixel clock
    logic sy1_q, sy2_q, sy3_q;
    logic [10:0] h_d, v_d;
    lpc_pins_t pins_q, pins_d;
    logic [17:0] data_q, data_d;
    logic take_q, take_d, revt_q, revt_d;
    logic smart_q, smart_d, dual_q, dual_d, rsvd_q, rsvd_d;
    logic run, rise, fall, launch, special, valid, de_act, hs_act, vs_act;
    logic pcp_eff, hsp_eff;

    always_comb
    begin
        run = ctrl_q[CTRL_ENABLE_BIT];
        // Edge finding looks only past the first sync stage
        rise = sy2_q && !sy3_q;
        fall = !sy2_q && sy3_q;
        // polarity choice can be switched off
        pcp_eff = cfg_q.pixclk_polarity && !cfg_q.pixclk_pol_func_disable;
        // launch edge per pixel clock polarity
        launch = pcp_eff ? fall : rise;
        // hsync polarity choice can be switched off
        hsp_eff = cfg_q.hsync_polarity && !cfg_q.hsync_pol_func_disable;
        valid = !((cfg_q.mode == 4'h5) || (cfg_q.mode == 4'h7) ||
                  (cfg_q.mode > MODE_TFT_SERIAL8));
        special = (cfg_q.mode >= MODE_TFT_SPECIAL1) &&
                  (cfg_q.mode <= MODE_TFT_SPECIAL3);

        h_d = h_q;
        v_d = v_q;
        // columns in pixel clocks, rows in lines
        if (!run)
        begin
            h_d = 11'h000;
            v_d = 11'h000;
        end
        else if (rise)
        begin
            if (h_q >= fld_hi(vat_q))
            begin
                h_d = 11'h000;
                v_d = (v_q >= fld_lo(vat_q)) ? 11'h000 : v_q + 11'h001;
            end
            else
            begin
                h_d = h_q + 11'h001;
            end
        end

        hs_act = in_win(h_q, fld_hi(hsync_q), fld_lo(hsync_q));
        // vsync window opens at row zero
        vs_act = v_q < fld_lo(vsync_q);
        de_act = in_win(h_q, fld_hi(dah_q), fld_lo(dah_q)) &&
                 in_win(v_q, fld_hi(dav_q), fld_lo(dav_q));

        pins_d = pins_q;
        revt_d = revt_q;
        data_d = data_q;
        take_d = 1'b0;
        // smart panel owns the pins, parallel set rests
        smart_d = cfg_q.pin_group_select;
        // second descriptor set only for dual STN
        dual_d = (cfg_q.mode == MODE_STN_DUAL_CLR) ||
                 (cfg_q.mode == MODE_STN_DUAL_MONO);
        rsvd_d = !valid;
        // sync pins driven only when set to output
        pins_d.sync_oe = run && valid && !cfg_q.pin_group_select &&
                         !cfg_q.sync_direction;

        if (!run || !valid || cfg_q.pin_group_select)
        begin
            pins_d.hsync = hsp_eff;
            pins_d.vsync = cfg_q.vsync_polarity;
            pins_d.panel_data_enable = cfg_q.data_enable_polarity;
            pins_d.panel_power_signal = cfg_q.power_pin_idle_level;
            pins_d.line_clear = cfg_q.line_clear_pin_idle_level;
            pins_d.start_pulse = cfg_q.start_pulse_pin_idle_level;
            pins_d.reverse = cfg_q.reverse_pin_idle_level;
            revt_d = 1'b0;
            data_d = DMASK_NONE;
        end
        else
        begin
            if (rise)
            begin
                pins_d.hsync = hs_act ^ hsp_eff;
                pins_d.vsync = vs_act ^ cfg_q.vsync_polarity;
                pins_d.panel_data_enable = de_act ^ cfg_q.data_enable_polarity;
                // special timing only in special TFT modes
                if (special && h_q == fld_hi(rev_q))
                begin
                    revt_d = !revt_q;
                end
                // each special pin gated by its disable bit
                pins_d.panel_power_signal = cfg_q.power_pin_idle_level ^
                    (special && !cfg_q.power_sig_disable &&
                     in_win(h_q, fld_hi(ps_q), fld_lo(ps_q)));
                pins_d.line_clear = cfg_q.line_clear_pin_idle_level ^
                    (special && !cfg_q.line_clear_sig_disable &&
                     in_win(h_q, fld_hi(cls_q), fld_lo(cls_q)));
                pins_d.start_pulse = cfg_q.start_pulse_pin_idle_level ^
                    (special && !cfg_q.start_pulse_sig_disable &&
                     in_win(h_q, fld_hi(spl_q), fld_lo(spl_q)));
                pins_d.reverse = cfg_q.reverse_pin_idle_level ^
                    (special && !cfg_q.reverse_sig_disable && revt_q);
            end
            if (launch)
            begin
                take_d = de_act;
                data_d = de_act ? ((i_pix_data ^ {18{cfg_q.data_invert}}) &
                                   data_mask(cfg_q)) : DMASK_NONE;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sy1_q <= 1'b0;
            sy2_q <= 1'b0;
            sy3_q <= 1'b0;
            h_q <= 11'h000;
            v_q <= 11'h000;
            pins_q <= '0;
            revt_q <= 1'b0;
            data_q <= DMASK_NONE;
            take_q <= 1'b0;
            smart_q <= 1'b0;
            dual_q <= 1'b0;
            rsvd_q <= 1'b0;
        end
        else
        begin
            sy1_q <= i_pclk_pin;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            h_q <= h_d;
            v_q <= v_d;
            pins_q <= pins_d;
            revt_q <= revt_d;
            data_q <= data_d;
            take_q <= take_d;
            smart_q <= smart_d;
            dual_q <= dual_d;
            rsvd_q <= rsvd_d;
        end
    end

    // ==========================================================
    // Outputs
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_pix_take = take_q;
    assign o_data = data_q;
    assign o_pins = pins_q;
    assign o_smart_panel_interface = smart_q;
    assign o_dual_desc_en = dual_q;
    assign o_mode_reserved = rsvd_q;

endmodule : lpc_panel_out

`default_nettype wire

/* File: lpc_panel_out_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checker
module lpc_chk (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_pix_take,
    input wire logic [17:0] o_data,
    input wire lpc_pkg::lpc_pins_t o_pins,
    input wire logic o_smart_panel_interface,
    input wire logic o_dual_desc_en,
    input wire logic o_mode_reserved
);
    import lpc_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    a_apb_wait_state: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_smart_quiet: assert property (
        o_smart_panel_interface [*2] |-> o_data == 18'h0 && !o_pins.sync_oe)
        else $error("parallel pins active in smart mode");
    a_reserved_quiet: assert property (
        o_mode_reserved [*2] |-> o_data == 18'h0 && !o_pins.sync_oe)
        else $error("pins active in reserved mode");
    a_dual_flag: assert property (o_dual_desc_en |-> !o_mode_reserved)
        else $error("dual descriptors in reserved mode");
    // Pixel clock is far slower than the bus clock
    a_take_spacing: assert property (o_pix_take |=> !o_pix_take [*8])
        else $error("pixel taken twice in one pixel tick");
endmodule : lpc_chk
bind lpc_panel_out lpc_chk u_chk (.*);
`default_nettype wire

/* File: lpc_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// Panel side pixel clock
module lpc_panel_model (
    input wire logic i_run,
    input wire lpc_pkg::lpc_pins_t i_pins,
    output logic o_pclk,
    output int o_lines
);
    // Clock stands still while idle; offset keeps it off the bus clock edges
    initial
    begin
        o_pclk = 1'b0;
        #3;
        forever
        begin
            #80;
            o_pclk = i_run ? ~o_pclk : 1'b0;
        end
    end
    int line_cnt = 0;
    always @(posedge i_pins.hsync) line_cnt++;
    assign o_lines = line_cnt;
endmodule : lpc_panel_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench top
module tb_top;
    import lpc_pkg::*;
    logic clk, nrst, psel, pen, pwr, pclk, rdy, err, take, smart, dual, resv, e;
    logic [31:0] paddr, pwdata, rdata, r;
    logic [17:0] pix, dout;
    logic [7:0] xp;
    lpc_pins_t pins;
    logic [15:0] seed = 16'h8a15;
    logic run = 1'b0;
    int fail_count = 0;
    int checks = 0;
    logic [31:0] ofs [6] = '{OFS_PANEL_CONFIG, OFS_VSYNC_PULSE_POS, OFS_HSYNC_PULSE_POS,
        OFS_REVERSE_SIG_TIMING, OFS_INTERRUPT_FRAME_ID, OFS_DISPLAY_AREA_VERT};
    logic [31:0] msk [6] = '{32'h80ff_ffbf, 32'h0000_07ff, 32'h07ff_07ff, 32'h07ff_0000,
        32'h0, 32'h07ff_07ff};
    logic [31:0] cfg [11] = '{32'h0, 32'h80, 32'h2_0004, 32'h28, 32'h19, 32'h2b, 32'h1b,
        32'h3b, 32'h2_003c, 32'h4_ff00, 32'h9_0800};
    lpc_panel_out DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(rdata),
        .o_pready(rdy), .o_pslverr(err), .i_pclk_pin(pclk), .i_pix_data(pix),
        .o_pix_take(take), .o_data(dout), .o_pins(pins),
        .o_smart_panel_interface(smart), .o_dual_desc_en(dual), .o_mode_reserved(resv));
    lpc_panel_model PANEL (.i_run(run), .i_pins(pins), .o_pclk(pclk), .o_lines());
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Expected data pins per display type and width
    function automatic logic [17:0] pmask(input logic [31:0] c);
        if (c[3:2] == 2'h0)
            return c[7] ? 18'h3ffff : 18'h0ffff;
        if (c[3:0] == 4'hb)
            return c[5] ? (c[4] ? 18'h0ffff : 18'h00f0f) : 18'h0;
        if (c[3:2] == 2'h2)
            return (18'h1 << (1 << c[5:4])) - 18'h1;
        return 18'h000ff;
    endfunction : pmask
    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic bad(input string m);
        fail_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : bad
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
            bad($sformatf("reg %h exp %h", g, x));
    endtask : chk_reg
    task automatic chk_pin(input logic [17:0] g, input logic [17:0] x);
        checks++;
        if (g !== x)
            bad($sformatf("pins %h exp %h", g, x));
    endtask : chk_pin
    // ====================
    // Bus and link drivers
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rdy !== 1'b1 && n < 20);
        r = rdata;
        e = err;
        if (rdy !== 1'b1)
        begin
            bad("bus timeout");
            wrap_up();
        end
        psel <= 1'b0;
        pen <= 1'b0;
        // Idle edge keeps release and next setup apart
        @(posedge clk);
    endtask : apb
    task automatic wait_take();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (take !== 1'b1 && n < 1000);
        if (take !== 1'b1)
        begin
            bad("pixel timeout");
            wrap_up();
        end
    endtask : wait_take
    // ====================
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        {psel, pen, pwr, paddr, pwdata, pix} = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        foreach (ofs[i])
        begin
            apb(1'b0, ofs[i], 32'h0);
            chk_reg(r, 32'h0);
            apb(1'b1, ofs[i], 32'hffff_ffff);
            apb(1'b0, ofs[i], 32'h0);
            chk_reg(r, msk[i]);
        end
        apb(1'b0, 32'h1305_0028, 32'h0);
        chk_pin({17'h0, e}, 18'h1);
        for (int m = 0; m < 16; m++)
        begin
            apb(1'b1, OFS_PANEL_CONFIG, 32'(m));
            repeat (2) @(posedge clk);
            chk_pin({16'h0, dual, resv}, {16'h0, m[3:1] == 3'h5, m inside {5, 7, [13:15]}});
        end
        apb(1'b1, OFS_PANEL_CONFIG, 32'h8000_0000);
        repeat (2) @(posedge clk);
        chk_pin({17'h0, smart}, 18'h1);
        apb(1'b1, OFS_VIRTUAL_AREA_SIZE, 32'h0014_0005);
        apb(1'b1, OFS_DISPLAY_AREA_HORIZ, 32'h0000_0014);
        apb(1'b1, OFS_DISPLAY_AREA_VERT, 32'h0000_0005);
        apb(1'b1, OFS_CONTROLLER_CONTROL, 32'h8);
        run <= 1'b1;
        foreach (cfg[i])
        begin
            apb(1'b1, OFS_PANEL_CONFIG, cfg[i]);
            seed = lfsr(seed);
            pix <= {seed[1:0], seed};
            wait_take();
            wait_take();
            chk_pin(dout, pmask(cfg[i]) & (cfg[i][17] ? ~pix : pix));
            // Hsync window is empty and vsync window covers every line, so only levels show
            xp = {cfg[i][11] & ~cfg[i][19], ~cfg[i][8], ~cfg[i][16], ~cfg[i][9], cfg[i][15:12]};
            chk_pin({10'h0, pins}, {10'h0, xp});
        end
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
